// ---- bench/bcfc_motor_model.sv ----
// bcfc_motor_model: motor encoder and six-switch power stage
// assumes the bench sets the shaft code and steps the speed wheel
`timescale 1ns/1ps
module bcfc_motor_model
	import bcfc_pkg::*;
(
	// clock
	input  wire logic       ref_clk,
	// shaft stimulus
	input  wire logic [2:0] pos_code,
	input  wire logic       step,
	input  wire logic       fwd,
	// power stage
	input  wire logic [5:0] gate,
	// encoder channels and stage alarm
	output bcfc_pos_t       rotor_pos,
	output logic            speed_quad_a,
	output logic            speed_quad_b,
	output logic            bad_gate
);
	logic [1:0] ph_q  = 2'h0;
	logic       bad_q = 1'b0;
	assign bad_gate = bad_q;
	always_ff @(posedge ref_clk) begin
		rotor_pos <= pos_code;
		if (step) begin
			ph_q <= fwd ? ph_q + 2'h1 : ph_q - 2'h1;
		end
	end
	// gray order, a ahead of b when turning forward
	assign speed_quad_a = ph_q[1] ^ ph_q[0];
	assign speed_quad_b = ph_q[1];
	// a third switch or a shorted leg would wreck a real stage, so it latches
	always @(posedge ref_clk) begin
		if ($countones(gate) > 2 || (gate[2:0] & gate[5:3]) != 3'h0) begin
			bad_q <= 1'b1;
		end
	end
endmodule : bcfc_motor_model

// ---- bench/tb.sv ----
// tb: drives bcfc_top by bus and pins, scores results from a note queue
// assumes zero-wait slave and a short pwm period for simulation
`timescale 1ns/1ps
`define CMP(nm, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
	$display("BAD %s exp %h seen %h", nm, e, g); end end
module tb;
	import bcfc_pkg::*;
	typedef struct {string nm; int sel; logic [31:0] exp;} bcfc_note_t;
	localparam int unsigned PER = 64;
	localparam logic [5:0] COMM [8] = '{6'h00, 6'h11, 6'h0c, 6'h14, 6'h22, 6'h21, 6'h0a, 6'h00};
	logic        ref_clk = 1'b0, sys_rst = 1'b1, hwrite = 1'b0, run_cmd = 1'b0, run_req = 1'b0;
	logic        interlock_ok = 1'b0, ext_freq_sel = 1'b0, ext_freq = 1'b0, int_freq = 1'b0;
	logic        step = 1'b0, fwd = 1'b1, hreadyout, hresp, ref_freq, drive_ok, enable_ack;
	logic        fb_pulse, rot_dir, sw_led, bad_gate, speed_quad_a, speed_quad_b;
	logic [1:0]  htrans = 2'h0, reset_sel = 2'h0;
	logic [2:0]  pos_code = 3'h0, pos_led;
	logic [5:0]  gate, g;
	logic [11:0] cur_ref = 12'hfff, cur_meas = 12'h000;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_q, meas, c0, r;
	bcfc_pos_t   rotor_pos;
	bcfc_fault_t fault_in = '0;
	int          fail_count = 0, checks = 0, on_n, rise_n;
	bcfc_note_t  notes[$], n_q;
	event        probe;

	bcfc_top #(.PWM_PERIOD(PER)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.rotor_pos(rotor_pos), .speed_quad_a(speed_quad_a), .speed_quad_b(speed_quad_b),
		.fault_in(fault_in), .reset_sel(reset_sel), .run_cmd(run_cmd), .run_req(run_req),
		.interlock_ok(interlock_ok), .cur_ref(cur_ref), .cur_meas(cur_meas),
		.ext_freq_sel(ext_freq_sel), .ext_freq(ext_freq), .int_freq(int_freq),
		.ref_freq(ref_freq), .gate(gate), .drive_ok(drive_ok), .enable_ack(enable_ack),
		.fb_pulse(fb_pulse), .rot_dir(rot_dir), .pos_led(pos_led), .sw_led(sw_led));
	bcfc_motor_model motor (.ref_clk(ref_clk), .pos_code(pos_code), .step(step), .fwd(fwd),
		.gate(gate), .rotor_pos(rotor_pos), .speed_quad_a(speed_quad_a),
		.speed_quad_b(speed_quad_b), .bad_gate(bad_gate));

	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end
	function automatic logic [31:0] obs(int sel);
		case (sel)
			0: return rd_q;
			1: return {26'h0, gate};
			2: return {31'h0, drive_ok};
			3: return {31'h0, enable_ack};
			4: return {29'h0, pos_led};
			5: return {31'h0, sw_led};
			6: return {31'h0, rot_dir};
			7: return {31'h0, ref_freq};
			9: return {31'h0, rd_q[ST_FAULT]};
			default: return meas;
		endcase
	endfunction : obs
	// notes are sampled mid-cycle, then the bench resumes on a rising edge
	task automatic note(string nm, int sel, logic [31:0] e);
		@(negedge ref_clk);
		notes.push_back('{nm, sel, e});
		-> probe;
		@(posedge ref_clk);
	endtask : note
	task automatic tick(int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick
	task automatic ahb(logic wr, logic [7:0] a, logic [31:0] wd);
		@(posedge ref_clk);
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd_q = hrdata;
	endtask : ahb
	task automatic count_on();
		logic prev;
		on_n = 0;
		rise_n = 0;
		prev = |gate;
		repeat (10 * PER) begin
			@(negedge ref_clk);
			on_n += |gate;
			rise_n += (|gate) & ~prev;
			prev = |gate;
		end
	endtask : count_on
	task automatic give_verdict();
		@(negedge ref_clk);
		if (fail_count == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict
	initial begin : watch
		forever begin
			@(probe);
			while (notes.size() > 0) begin
				n_q = notes.pop_front();
				`CMP(n_q.nm, n_q.exp, obs(n_q.sel))
			end
		end
	end
	initial begin : dog
		#400000;
		fail_count++;
		give_verdict();
	end
	initial begin : main
		void'($urandom(15));
		tick(16);
		sys_rst <= 1'b0;
		tick(2);
		note("drive_ok", 2, 1);
		ahb(0, OFS_CTRL, 0);
		note("ctrl_rst", 0, 0);
		ahb(0, 8'h0c, 0);
		note("unmapped", 0, 0);
		meas = {hreadyout, hresp};
		note("bus_resp", 8, 32'h2);
		ahb(1, OFS_CTRL, 32'h1);
		run_cmd <= 1'b1;
		run_req <= 1'b1;
		interlock_ok <= 1'b1;
		tick(3);
		note("ack", 3, 1);
		for (int d = 0; d < 2; d++) begin
			ahb(1, OFS_CTRL, 32'h1 | (32'(d) << CTRL_DIR));
			for (int c = 0; c < 8; c++) begin
				pos_code <= 3'(c);
				tick(4);
				g = d ? {COMM[c][2:0], COMM[c][5:3]} : COMM[c];
				note("gate", 1, g);
				note("pos_led", 4, c);
				note("sw_led", 5, g != 0);
			end
		end
		interlock_ok <= 1'b0;
		tick(3);
		note("ack_ilk", 3, 0);
		interlock_ok <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			r = $urandom;
			ext_freq <= r[0];
			int_freq <= r[1];
			ext_freq_sel <= r[2];
			tick(2);
			note("ref_freq", 7, r[2] ? r[0] : r[1]);
		end
		ahb(1, OFS_CTRL, 32'h1);
		pos_code <= 3'h1;
		for (int k = 0; k < 3; k++) begin
			cur_ref <= (k == 0) ? 12'h0 : 12'h1;
			cur_meas <= (k == 2) ? 12'h2 : 12'h0;
			tick(PER);
			count_on();
			meas = (k == 2) ? (on_n < 320) : on_n;
			note("pwm_on", 8, (k == 1) ? 320 : (k == 2));
			meas = rise_n;
			if (k == 1) note("pwm_rate", 8, 10);
		end
		cur_ref <= 12'hfff;
		cur_meas <= 12'h0;
		for (int m = 0; m < 3; m++) begin
			ahb(1, OFS_CTRL, 32'h1 | (32'(m) << CTRL_MUL));
			ahb(0, OFS_FBCNT, 0);
			c0 = rd_q;
			repeat (16) begin
				step <= 1'b1;
				tick(1);
				step <= 1'b0;
				tick(4);
			end
			ahb(0, OFS_FBCNT, 0);
			meas = (rd_q - c0) & 32'hffff;
			note("fb_cnt", 8, 16 >> m);
			note("rot_dir", 6, 1);
		end
		fwd <= 1'b0;
		repeat (4) begin
			step <= 1'b1;
			tick(1);
			step <= 1'b0;
			tick(4);
		end
		note("rot_rev", 6, 0);
		run_cmd <= 1'b0;
		tick(3);
		note("stop", 2, 1);
		run_cmd <= 1'b1;
		for (int f = 0; f < 5; f++) begin
			fault_in <= bcfc_fault_t'(5'h1 << f);
			tick(1);
			fault_in <= '0;
			tick(3);
			note("drive_ok_f", 2, 0);
			note("ack_f", 3, 0);
			note("gate_f", 1, 0);
			ahb(0, OFS_STATUS, 0);
			note("st_fault", 9, 1);
			run_cmd <= 1'b0;
			tick(4);
			note("auto_clr", 2, 1);
			run_cmd <= 1'b1;
		end
		reset_sel <= BCFC_SEL_MAN;
		fault_in <= 5'h02;
		tick(1);
		fault_in <= '0;
		run_cmd <= 1'b0;
		tick(4);
		note("man_hold", 2, 0);
		run_cmd <= 1'b1;
		reset_sel <= BCFC_SEL_MID;
		tick(4);
		note("mid_run", 2, 0);
		run_cmd <= 1'b0;
		tick(4);
		note("mid_clr", 2, 1);
		note("mid_ack", 3, 0);
		note("mid_gate", 1, 0);
		meas = bad_gate;
		note("stage", 8, 0);
		give_verdict();
	end
endmodule : tb

// ---- hw/bcfc_top.sv ----
// bcfc_top: commutation, pwm current limit, speed feedback and fault latch
// assumes all pins synchronous to ref_clk; one AHB-Lite slave, zero wait
// Behaviour
// - at most two output switches on at any time
// - pwm period never shorter than 1/1.8 kHz
// - six separate switch drive outputs to the base driver
// - pulse on-time grows with load (current reference)
// - any fault indication latches a fault and locks the drive out
// - drive-healthy output high unless fault latched
// - stop or run removal never sets the fault latch
// - automatic setting clears the fault when run command drops
// - manual setting clears only by power cycle or middle with no run
// - middle setting refuses to run, all switch outputs off
// - external select routes external pulse train as reference
// - enable acknowledge returned only while no fault is latched
// - interlock gates the run-enable request
// - each pwm pulse is cut when current exceeds reference
// - position bits and complements address the commutation table
// - switches follow position and commanded direction
// - quadrature edges give x4, x2 or x1 feedback
// - x4 is the default multiplier
// - feedback and direction come from the quadrature pair
// - three indicators follow the position channels
// - indicator lit while any switch is on
`timescale 1ns/1ps
module bcfc_top
	import bcfc_pkg::*;
#(
	parameter int unsigned PWM_PERIOD = PWM_PER_CYC
) (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              sys_rst,
	// AHB-Lite slave
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic [31:0]            hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	// encoder
	input  wire bcfc_pos_t         rotor_pos,
	input  wire logic              speed_quad_a,
	input  wire logic              speed_quad_b,
	// protection and control
	input  wire bcfc_fault_t       fault_in,
	input  wire logic [1:0]        reset_sel,
	input  wire logic              run_cmd,
	input  wire logic              run_req,
	input  wire logic              interlock_ok,
	input  wire logic [CUR_W-1:0]  cur_ref,
	input  wire logic [CUR_W-1:0]  cur_meas,
	// reference frequency
	input  wire logic              ext_freq_sel,
	input  wire logic              ext_freq,
	input  wire logic              int_freq,
	output logic                   ref_freq,
	// drive and status
	output logic [5:0]             gate,
	output logic                   drive_ok,
	output logic                   enable_ack,
	output logic                   fb_pulse,
	output logic                   rot_dir,
	output logic [2:0]             pos_led,
	output logic                   sw_led
);
	logic [3:0]            ctrl_q;
	logic                  fault_q;
	logic [4:0]            cause_q;
	logic                  en_q;
	logic [PWM_W-1:0]      pwm_q;
	logic                  cut_q;
	logic [5:0]            gate_q;
	logic                  qa_q;
	logic                  qb_q;
	logic                  fb_q;
	logic                  dir_q;
	logic [FB_W-1:0]       fbcnt_q;
	logic                  ref_q;
	logic [2:0]            led_q;
	logic                  swled_q;
	logic                  dok_q;
	logic                  dph_q;
	logic                  dwr_q;
	logic [7:0]            dadr_q;
	logic [31:0]           rd_q;
	logic                  rdy_q;
	logic                  resp_q;

	// bus decode
	wire        ap_valid = hsel & htrans[1] & hready;
	wire [7:0]  ap_adr   = haddr[7:0];
	wire        wr_ctrl  = dph_q & dwr_q & (dadr_q == OFS_CTRL);
	wire [31:0] st_word  = {21'h0, dir_q, rotor_pos, en_q, cause_q, fault_q};
	// unmapped offsets read zero rather than erroring, so probing software sees OKAY
	wire [31:0] rd_d     = (ap_adr == OFS_CTRL)   ? {28'h0, ctrl_q} :
	                       (ap_adr == OFS_STATUS) ? st_word :
	                       (ap_adr == OFS_FBCNT)  ? {16'h0, fbcnt_q} : 32'h0;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dph_q  <= 1'b0;
			dwr_q  <= 1'b0;
			dadr_q <= 8'h00;
			rd_q   <= 32'h0;
		end else begin
			dph_q  <= ap_valid;
			dwr_q  <= ap_valid & hwrite;
			dadr_q <= ap_adr;
			if (ap_valid & ~hwrite)
				rd_q <= rd_d;
		end
	end

	// response flops keep every bus output registered; zero wait, always OKAY
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdy_q  <= 1'b1;
			resp_q <= 1'b0;
		end else begin
			rdy_q  <= 1'b1;
			resp_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			ctrl_q <= CTRL_RST;
		else if (wr_ctrl)
			ctrl_q <= hwdata[3:0];
	end

	// fault latch and its clearing policy
	wire       any_fault = |fault_in;
	wire       sel_mid   = (reset_sel == BCFC_SEL_MID);
	wire       sel_auto  = (reset_sel == BCFC_SEL_AUTO);
	wire       clr_auto  = sel_auto & ~run_cmd;
	// manual clear only via middle with run absent
	wire       clr_mid   = sel_mid & ~run_cmd;
	wire       fault_clr = clr_auto | clr_mid;

	// only fault inputs set the latch
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			fault_q <= 1'b0;
			cause_q <= 5'h00;
		end else if (any_fault) begin
			fault_q <= 1'b1;
			cause_q <= cause_q | fault_in;
		end else if (fault_clr) begin
			fault_q <= 1'b0;
			cause_q <= 5'h00;
		end
	end

	wire en_d = run_req & interlock_ok & ~fault_q & ~any_fault & ~sel_mid
	            & ctrl_q[CTRL_RUN];

	// period fixed at the rate ceiling
	wire pwm_wrap = (pwm_q == PWM_W'(PWM_PERIOD - 1));
	// on-time tracks the load reference
	// large references saturate to full on; the period bounds the rate anyway
	wire [PWM_W-1:0] duty = {cur_ref, {DUTY_SHIFT{1'b0}}};
	wire             pwm_on = (pwm_q < duty);
	wire over  = cur_meas > cur_ref;
	wire cut_d = pwm_wrap ? 1'b0 : (cut_q | over);

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pwm_q <= '0;
			cut_q <= 1'b0;
		end else begin
			pwm_q <= pwm_wrap ? '0 : pwm_q + 1'b1;
			cut_q <= cut_d;
		end
	end

	// position and complements form the address
	wire [5:0] tbl_adr = {~rotor_pos, rotor_pos};
	logic [5:0] tbl_gate;
	// one leg per side, bad codes give zero
	// each entry has at most two bits set
	always_comb begin
		case (tbl_adr)
			6'b110_001: tbl_gate = 6'b010_001;
			6'b101_010: tbl_gate = 6'b001_100;
			6'b100_011: tbl_gate = 6'b010_100;
			6'b011_100: tbl_gate = 6'b100_010;
			6'b010_101: tbl_gate = 6'b100_001;
			6'b001_110: tbl_gate = 6'b001_010;
			default:    tbl_gate = 6'b000_000;
		endcase
	end
	// reverse swaps upper and lower banks
	wire [5:0] dir_gate = ctrl_q[CTRL_DIR] ? {tbl_gate[2:0], tbl_gate[5:3]}
	                                       : tbl_gate;
	// six independent drives, gated by enable and pwm
	// a fault or the middle setting blanks the gates in the same cycle,
	// not one cycle later through en_q
	wire       drive  = en_q & ~any_fault & ~sel_mid & pwm_on & ~cut_d & ~over;
	wire [5:0] gate_d = drive ? dir_gate : 6'h00;

	// quadrature edges
	wire ea_r = speed_quad_a & ~qa_q;
	wire ea_f = ~speed_quad_a & qa_q;
	wire eb   = speed_quad_b ^ qb_q;
	wire fb_d = (ctrl_q[2:1] == BCFC_MUL_X4) ? (ea_r | ea_f | eb) :
	            (ctrl_q[2:1] == BCFC_MUL_X2) ? (ea_r | ea_f) :
	            (ctrl_q[2:1] == BCFC_MUL_X1) ? ea_r : 1'b0;
	// b level at a's rising edge gives direction
	wire dir_d = ea_r ? ~speed_quad_b : dir_q;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			qa_q    <= 1'b0;
			qb_q    <= 1'b0;
			fb_q    <= 1'b0;
			dir_q   <= 1'b0;
			fbcnt_q <= '0;
		end else begin
			qa_q    <= speed_quad_a;
			qb_q    <= speed_quad_b;
			fb_q    <= fb_d;
			dir_q   <= dir_d;
			fbcnt_q <= fbcnt_q + FB_W'(fb_d);
		end
	end

	// outputs, each from its own flop
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			en_q   <= 1'b0;
			gate_q <= 6'h00;
		end else begin
			en_q   <= en_d;
			gate_q <= gate_d;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			ref_q <= 1'b0;
		else
			ref_q <= ext_freq_sel ? ext_freq : int_freq;
	end

	// indicators trail their sources by one cycle
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			led_q   <= 3'h0;
			swled_q <= 1'b0;
		end else begin
			led_q   <= rotor_pos;
			swled_q <= |gate_d;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			dok_q <= 1'b0;
		else
			dok_q <= ~fault_q & ~any_fault;
	end

	assign hrdata     = rd_q;
	assign hreadyout  = rdy_q;
	assign hresp      = resp_q;
	assign gate       = gate_q;
	assign drive_ok   = dok_q;
	assign enable_ack = en_q;
	assign fb_pulse   = fb_q;
	assign rot_dir    = dir_q;
	assign pos_led    = led_q;
	assign sw_led     = swled_q;
	assign ref_freq   = ref_q;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	a_gate_two_on: assert property ($countones(gate_q) <= 2)
		else $error("more than two switches on");
	a_gate_leg: assert property ((gate_q[5:3] & gate_q[2:0]) == 3'h0)
		else $error("both switches of a leg on");
	a_gate_bad_pos: assert property ((rotor_pos == 3'h0 || rotor_pos == 3'h7)
		|=> gate_q == 6'h00)
		else $error("invalid position drives switches");
	a_pwm_period: assert property (pwm_wrap |=> pwm_q == '0)
		else $error("pwm period wrong");
	a_fault_lock: assert property (any_fault |=> fault_q && !en_q
		##1 gate_q == 6'h00)
		else $error("fault did not lock out drive");
	a_drive_ok: assert property (fault_q |=> !drive_ok)
		else $error("healthy shown with fault");
	a_auto_clear: assert property (fault_q && sel_auto && !run_cmd && !any_fault
		|=> !fault_q ##1 (drive_ok || $past(any_fault)))
		else $error("auto clear failed");
	a_man_hold: assert property (fault_q && reset_sel == BCFC_SEL_MAN && !any_fault
		|=> fault_q)
		else $error("manual fault cleared");
	a_mid_block: assert property (sel_mid |=> !en_q ##1 gate_q == 6'h00)
		else $error("ran in middle setting");
	a_enable_ack: assert property (en_q |-> $past(run_req) && $past(interlock_ok)
		&& !$past(fault_q))
		else $error("enable without clean request");
	a_cur_cut: assert property (over && !pwm_wrap |=> gate_q == 6'h00
		##1 ($past(pwm_wrap) || gate_q == 6'h00))
		else $error("pulse not cut on over-current");
	a_ext_freq: assert property (ext_freq_sel |=> ref_freq == $past(ext_freq))
		else $error("external frequency not routed");
	a_fb_x1: assert property ($past(ctrl_q[2:1]) == BCFC_MUL_X1 && fb_pulse
		|-> $past(ea_r))
		else $error("x1 pulse without a rising edge");
	a_sw_led: assert property (sw_led == (gate_q != 6'h00))
		else $error("switch indicator mismatch");

	// protection paths
	a_ilk_block: assert property (!interlock_ok |=> !en_q)
		else $error("enable with interlock open");
	a_ack_fault: assert property (fault_q |=> !en_q)
		else $error("enable while fault latched");
	a_no_false_set: assert property (!any_fault && !fault_q |=> !fault_q)
		else $error("fault set without a fault input");
	a_mid_clear: assert property (fault_q && sel_mid && !run_cmd && !any_fault
		|=> !fault_q)
		else $error("middle setting did not clear");
	a_dok_fault: assert property (any_fault |=> !drive_ok)
		else $error("healthy shown on fault input");
	a_gate_idle: assert property (!en_q |=> gate_q == 6'h00)
		else $error("switches on without enable");

	// modulation, reference routing and position indicator
	a_pwm_off: assert property (!pwm_on |=> gate_q == 6'h00)
		else $error("switch on outside pulse");
	a_cut_hold: assert property (cut_q && !pwm_wrap |=> gate_q == 6'h00)
		else $error("cut pulse restarted early");
	a_ref_int: assert property (!ext_freq_sel |=> ref_freq == $past(int_freq))
		else $error("internal frequency not routed");
	a_pos_led: assert property (1'b1 |=> pos_led == $past(rotor_pos))
		else $error("position indicator mismatch");

	// speed feedback
	a_fb_x4: assert property (ctrl_q[2:1] == BCFC_MUL_X4 && (ea_r || ea_f || eb)
		|=> fb_pulse)
		else $error("x4 edge not counted");
	a_fb_x2: assert property (ctrl_q[2:1] == BCFC_MUL_X2 && eb && !ea_r && !ea_f
		|=> !fb_pulse)
		else $error("x2 counted a b edge");
	a_fb_none: assert property (ctrl_q[2:1] == 2'b11 |=> !fb_pulse)
		else $error("pulse with unused multiplier");
	a_dir_fwd: assert property (ea_r && !speed_quad_b |=> rot_dir)
		else $error("forward direction not seen");
	a_dir_rev: assert property (ea_r && speed_quad_b |=> !rot_dir)
		else $error("reverse direction not seen");
endmodule : bcfc_top

// ---- inc/bcfc_pkg.sv ----
// bcfc_pkg: constants and types for the brushless commutation and fault block
// assumes a 200 MHz ref_clk and a 32-bit AHB-Lite register bus
package bcfc_pkg;
	localparam int unsigned CLK_HZ      = 200_000_000;
	localparam int unsigned PWM_MAX_HZ  = 1800;
	// least period rounds up so the rate never passes the ceiling
	localparam int unsigned PWM_PER_CYC = (CLK_HZ + PWM_MAX_HZ - 1) / PWM_MAX_HZ;
	localparam int unsigned PWM_W       = 17;
	localparam int unsigned CUR_W       = 12;
	localparam int unsigned DUTY_SHIFT  = 5;
	localparam int unsigned FB_W        = 16;

	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_FBCNT  = 8'h08;

	localparam int unsigned CTRL_RUN  = 0;
	localparam int unsigned CTRL_MUL  = 1;
	localparam int unsigned CTRL_DIR  = 3;
	localparam logic [3:0]  CTRL_RST  = 4'h0;

	localparam int unsigned ST_FAULT  = 0;
	localparam int unsigned ST_CAUSE  = 1;
	localparam int unsigned ST_EN     = 6;
	localparam int unsigned ST_POS    = 7;
	localparam int unsigned ST_DIR    = 10;

	typedef enum logic [1:0] {
		BCFC_MUL_X4 = 2'b00,
		BCFC_MUL_X2 = 2'b01,
		BCFC_MUL_X1 = 2'b10
	} bcfc_mul_t;

	typedef enum logic [1:0] {
		BCFC_SEL_AUTO = 2'b00,
		BCFC_SEL_MID  = 2'b01,
		BCFC_SEL_MAN  = 2'b10
	} bcfc_rsel_t;

	typedef struct packed {
		logic bus_voltage_fault;
		logic overcurrent;
		logic base_driver;
		logic power_loss;
		logic monitor;
	} bcfc_fault_t;

	typedef struct packed {
		logic rotor_position_c;
		logic rotor_position_b;
		logic rotor_position_a;
	} bcfc_pos_t;
endpackage : bcfc_pkg
